// File: src/nsi_pkg.sv
/*
  Constants for the NMI and software-interrupt input block: cause codes,
  selector encodings and reset values.
  Assumes a single core clock and a synchronous active-low reset.
*/
package nsi_pkg;
  localparam logic [31:0] NSI_CAUSE_PIN = 32'h0000_0000;
  localparam logic [31:0] NSI_CAUSE_STORE = 32'hf000_0000;
  localparam logic [31:0] NSI_CAUSE_LOAD = 32'hf000_0001;
  localparam logic [31:0] NSI_CAUSE_FI_DBE = 32'hf000_1000;
  localparam logic [31:0] NSI_CAUSE_FI_DCCM = 32'hf000_1001;
  localparam logic [31:0] NSI_CAUSE_FI_NONDCCM = 32'hf000_1002;
  localparam logic [31:0] NSI_CAUSE_RST = 32'h0000_0000;
  localparam logic [31:0] NSI_PC_RST = 32'h0000_0000;
  localparam int NSI_NSRC = 6;
  localparam int NSI_SRC_PIN = 0;
  localparam int NSI_SRC_STORE = 1;
  localparam int NSI_SRC_LOAD = 2;
  localparam int NSI_SRC_FI_DBE = 3;
  localparam int NSI_SRC_FI_DCCM = 4;
  localparam int NSI_SRC_FI_NONDCCM = 5;
  typedef enum logic [0:0] {
    NSI_IDLE = 1'b0,
    NSI_TAKE = 1'b1
  } nsi_state_type;
endpackage

// File: src/nsi_nmi_soft_irq.sv
/*
  NMI request pin, NMI vector and software-interrupt pin handling for one
  core: pin synchronisers, rising-edge detection on the NMI pin, a pending
  set for pin and internal error NMIs, a fixed-priority grant, and the
  registered redirect, vector and cause that the pipeline sees.
  Assumes the pins come from SoC logic, the error strobes arrive as
  one-cycle pulses on the core clock, MSIE is the live enable bit, and the
  pipeline consumes the redirect pulse, the vector and the cause on
  REDIRECT.
  Limitation: an NMI pin pulse shorter than one core cycle may be lost,
  and a source that strobes again while still pending is taken once.
*/
// Notes on behaviour
// - The core accepts a 31-bit handler address on bits 31:1, driven constant or from a register.
// - NMI handling ignores all other interrupt sources and the direct or vectored mode.
// - The NMI pin is synchronised and a request is a rising edge, not a level.
// - A data-bus store error or non-blocking load error raises an internal NMI.
// - Any NMI redirects fetch to the address present on the handler address input.
// - A pin NMI writes cause 0x0000_0000.
// - A data-bus store error NMI writes cause 0xF000_0000.
// - A data-bus non-blocking load error NMI writes cause 0xF000_0001.
// - Fast-interrupt NMIs write 0xF000_1000, 0xF000_1001 or 0xF000_1002.
// - The software-interrupt pin is synchronised and drives the msip bit directly.
// - A machine software interrupt is taken when msip and msie are both set.
`timescale 1ns/1ns
module nsi_nmi_soft_irq
  import nsi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic NMI_REQ,
  input wire logic [31:1] NMI_VECTOR,
  input wire logic SOFT_IRQ,
  input wire logic MSIE,
  input wire logic STORE_ERR,
  input wire logic LOAD_ERR,
  input wire logic FI_DBE_ERR,
  input wire logic FI_DCCM_ERR,
  input wire logic FI_NONDCCM_ERR,
  output logic REDIRECT,
  output logic [31:0] REDIRECT_PC,
  output logic [31:0] MCAUSE,
  output logic MSIP,
  output logic SOFT_IRQ_TAKE
);

  logic nmi_s1_q;
  logic nmi_s2_q;
  logic nmi_prev_q;
  logic pin_edge_d;
  logic soft_s1_q;
  logic soft_s2_q;

  // one pending bit per NMI source; the index order is the priority
  logic [NSI_NSRC-1:0] pend_q;
  logic [NSI_NSRC-1:0] event_d;
  logic [NSI_NSRC-1:0] grant_d;
  logic take_d;
  logic [31:0] vector_d;
  logic [31:0] cause_d;
  nsi_state_type state_q;

  // lowest index wins; pin first, then bus errors, then fast-interrupt errors
  function automatic logic [NSI_NSRC-1:0] pick(input logic [NSI_NSRC-1:0] req);
    logic [NSI_NSRC-1:0] g;
    g = '0;
    for (int i = NSI_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  // one-hot grant in; the pin code stands when no error bit is set
  function automatic logic [31:0] cause_of(input logic [NSI_NSRC-1:0] g);
    logic [31:0] c;
    c = NSI_CAUSE_PIN;
    if (g[NSI_SRC_STORE]) c = NSI_CAUSE_STORE;
    if (g[NSI_SRC_LOAD]) c = NSI_CAUSE_LOAD;
    if (g[NSI_SRC_FI_DBE]) c = NSI_CAUSE_FI_DBE;
    if (g[NSI_SRC_FI_DCCM]) c = NSI_CAUSE_FI_DCCM;
    if (g[NSI_SRC_FI_NONDCCM]) c = NSI_CAUSE_FI_NONDCCM;
    return c;
  endfunction

  // first stage feeds only the second stage
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
    end else begin
      nmi_s1_q <= NMI_REQ;
      nmi_s2_q <= nmi_s1_q;
    end
  end

  // history resets to the idle pin level, so release gives no false edge
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s2_q;
    end
  end

  // level path: no edge detect, the pending bit simply follows the pin
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      soft_s1_q <= 1'b0;
      soft_s2_q <= 1'b0;
    end else begin
      soft_s1_q <= SOFT_IRQ;
      soft_s2_q <= soft_s1_q;
    end
  end

  // a pin held high gives a single event, whatever its length
  assign pin_edge_d = nmi_s2_q & ~nmi_prev_q;

  // error strobes are events; a level held n cycles raises n of them
  always_comb begin
    event_d = '0;
    event_d[NSI_SRC_PIN] = pin_edge_d;
    event_d[NSI_SRC_STORE] = STORE_ERR;
    event_d[NSI_SRC_LOAD] = LOAD_ERR;
    event_d[NSI_SRC_FI_DBE] = FI_DBE_ERR;
    event_d[NSI_SRC_FI_DCCM] = FI_DCCM_ERR;
    event_d[NSI_SRC_FI_NONDCCM] = FI_NONDCCM_ERR;
  end

  // independent of ordinary interrupt enables and dispatch mode
  assign grant_d = (state_q == NSI_IDLE) ? pick(pend_q) : '0;
  assign take_d = |grant_d;
  assign cause_d = cause_of(grant_d);
  assign vector_d = {NMI_VECTOR, 1'b0};

  // new events set over the grant clear so nothing is lost
  // a source repeating while still pending merges into one take
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~grant_d) | event_d;
    end
  end

  // one idle cycle between takes so the pipeline sees separate redirects
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q <= NSI_IDLE;
    end else begin
      unique case (state_q)
        NSI_IDLE: begin
          if (|pend_q) begin
            state_q <= NSI_TAKE;
          end
        end
        NSI_TAKE: begin
          state_q <= NSI_IDLE;
        end
      endcase
    end
  end

  // one-cycle pulse; the NSI_TAKE state after a take keeps pulses apart
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      REDIRECT <= 1'b0;
    end else begin
      REDIRECT <= take_d;
    end
  end

  // vector is sampled in the grant cycle, so a later change cannot tear it
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      REDIRECT_PC <= NSI_PC_RST;
    end else begin
      if (take_d) begin
        REDIRECT_PC <= vector_d;
      end
    end
  end

  // cause holds until the next take, so the handler may read it late
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      MCAUSE <= NSI_CAUSE_RST;
    end else begin
      if (take_d) begin
        MCAUSE <= cause_d;
      end
    end
  end

  // pending bit is the synchronised pin, never latched here
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      MSIP <= 1'b0;
    end else begin
      MSIP <= soft_s2_q;
    end
  end

  // same synchronised value as MSIP, so take and pending never disagree
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      SOFT_IRQ_TAKE <= 1'b0;
    end else begin
      SOFT_IRQ_TAKE <= soft_s2_q & MSIE;
    end
  end

endmodule

// File: tb/nsi_chk.sv
/* port checker for the nmi and soft interrupt block
   assumes it is bound to the block top, one core clock */
`timescale 1ns/1ns
module nsi_chk
  import nsi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic NMI_REQ,
  input wire logic [31:1] NMI_VECTOR,
  input wire logic SOFT_IRQ,
  input wire logic MSIE,
  input wire logic STORE_ERR,
  input wire logic LOAD_ERR,
  input wire logic FI_DBE_ERR,
  input wire logic FI_DCCM_ERR,
  input wire logic FI_NONDCCM_ERR,
  input wire logic REDIRECT,
  input wire logic [31:0] REDIRECT_PC,
  input wire logic [31:0] MCAUSE,
  input wire logic MSIP,
  input wire logic SOFT_IRQ_TAKE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  chk_one_pulse: assert property (REDIRECT |=> !REDIRECT)
    else $error("redirect longer than one cycle");
  chk_pc_vector: assert property (REDIRECT |-> REDIRECT_PC == {$past(NMI_VECTOR), 1'b0})
    else $error("redirect pc differs from vector");
  chk_store_cause: assert property (STORE_ERR |-> ##[2:12] (REDIRECT && MCAUSE == NSI_CAUSE_STORE))
    else $error("store error not taken");
  chk_load_cause: assert property (LOAD_ERR |-> ##[2:12] (REDIRECT && MCAUSE == NSI_CAUSE_LOAD))
    else $error("load error not taken");
  chk_dbe_cause: assert property (FI_DBE_ERR |-> ##[2:16] (REDIRECT && MCAUSE == NSI_CAUSE_FI_DBE))
    else $error("ecc error not taken");
  chk_dccm_cause: assert property (FI_DCCM_ERR |-> ##[2:16] (REDIRECT && MCAUSE == NSI_CAUSE_FI_DCCM))
    else $error("local region error not taken");
  chk_nondccm_cause: assert property (FI_NONDCCM_ERR |-> ##[2:16] (REDIRECT && MCAUSE == NSI_CAUSE_FI_NONDCCM))
    else $error("other region error not taken");
  chk_pin_cause: assert property ($rose(NMI_REQ) |-> ##[4:16] (REDIRECT && MCAUSE == NSI_CAUSE_PIN))
    else $error("pin edge not taken");
  chk_msip_sync: assert property (MSIP == $past(SOFT_IRQ, 3))
    else $error("pending bit does not follow pin");
  chk_soft_take: assert property (SOFT_IRQ_TAKE == (MSIP && $past(MSIE)))
    else $error("software take wrong");
  cover property (REDIRECT && MCAUSE == NSI_CAUSE_PIN);
  cover property (STORE_ERR && LOAD_ERR);
  cover property (SOFT_IRQ_TAKE);
  cover property (REDIRECT && MCAUSE == NSI_CAUSE_FI_NONDCCM);
endmodule

// File: tb/nsi_soc.sv
/* soc side model: shapes nmi pin requests, holds the software bit
   assumes fire and wr are strobed on falling edges */
`timescale 1ns/1ns
module nsi_soc (
  input wire logic clk,
  input wire logic fire,
  input wire logic wr,
  input wire logic wdata,
  output logic nmi_req,
  output logic soft_irq
);
  logic [2:0] cnt_q = 3'h0;
  logic bit_q = 1'b0;
  // a request while busy is ignored so the low gap is never cut short
  always_ff @(negedge clk) begin
    if (fire && cnt_q == 3'h0) begin
      cnt_q <= 3'h6;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  always_ff @(negedge clk) begin
    if (wr) begin
      bit_q <= wdata;
    end
  end
  assign nmi_req = (cnt_q > 3'h3);
  assign soft_irq = bit_q;
endmodule

// File: tb/test_nsi_nmi_soft_irq.sv
/* self-checking bench for the nmi and soft interrupt block
   assumes the soc model drives both pins */
`timescale 1ns/1ns
module test_nsi_nmi_soft_irq;
  import nsi_pkg::*;
  logic CLOCK = 1'b0, RESETN = 1'b0, MSIE = 1'b0, fire = 1'b0, wr = 1'b0, wdata = 1'b0;
  logic NMI_REQ, SOFT_IRQ, REDIRECT, MSIP, SOFT_IRQ_TAKE;
  logic [4:0] err = 5'h0;
  logic [31:1] vec = 31'h0;
  logic [31:0] REDIRECT_PC, MCAUSE;
  logic [31:0] tab [5] = '{NSI_CAUSE_STORE, NSI_CAUSE_LOAD, NSI_CAUSE_FI_DBE,
    NSI_CAUSE_FI_DCCM, NSI_CAUSE_FI_NONDCCM};
  int n_fail = 0, n_tests = 0;
  nsi_soc i_nsi_soc (.clk(CLOCK), .fire, .wr, .wdata, .nmi_req(NMI_REQ), .soft_irq(SOFT_IRQ));
  nsi_nmi_soft_irq i_nsi_nmi_soft_irq (.CLOCK, .RESETN, .NMI_REQ, .NMI_VECTOR(vec), .SOFT_IRQ,
    .MSIE, .STORE_ERR(err[0]), .LOAD_ERR(err[1]), .FI_DBE_ERR(err[2]), .FI_DCCM_ERR(err[3]),
    .FI_NONDCCM_ERR(err[4]), .REDIRECT, .REDIRECT_PC, .MCAUSE, .MSIP, .SOFT_IRQ_TAKE);
  initial forever #5 CLOCK = ~CLOCK;
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_take(output int n);
    n = 0;
    while (REDIRECT !== 1'b1 && n < 20) begin
      @(negedge CLOCK);
      n++;
    end
  endtask
  task automatic t_err(int i);
    int n;
    vec <= 31'h1000_0000 + 31'(i);
    err[i] <= 1'b1;
    @(negedge CLOCK);
    err[i] <= 1'b0;
    wait_take(n);
    chk("latency", 32'(n), 32'h1);
    chk("cause", MCAUSE, tab[i]);
    chk("pc", REDIRECT_PC, {vec, 1'b0});
    repeat (3) @(negedge CLOCK);
    $display("error source %0d done", i);
  endtask
  task automatic t_pair();
    int n;
    err <= 5'h3;
    fire <= 1'b1;
    @(negedge CLOCK);
    err <= 5'h0;
    fire <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wait_take(n);
      chk("queued", MCAUSE, k == 2 ? NSI_CAUSE_PIN : tab[k]);
      @(negedge CLOCK);
    end
    repeat (6) begin
      @(negedge CLOCK);
      chk("single take", 32'(REDIRECT), 32'h0);
    end
    $display("queued takes done");
  endtask
  task automatic t_soft(logic v);
    wr <= 1'b1;
    wdata <= v;
    @(negedge CLOCK);
    wr <= 1'b0;
    MSIE <= 1'b0;
    repeat (5) @(negedge CLOCK);
    chk("masked", 32'({MSIP, SOFT_IRQ_TAKE}), 32'({v, 1'b0}));
    MSIE <= 1'b1;
    t_err(0);
    chk("take", 32'(SOFT_IRQ_TAKE), 32'(v));
    $display("software pin %0d done", v);
  endtask
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge CLOCK);
    chk("reset", MCAUSE | REDIRECT_PC | 32'({REDIRECT, MSIP, SOFT_IRQ_TAKE}), 32'h0);
    RESETN <= 1'b1;
    @(negedge CLOCK);
    for (int i = 0; i < 5; i++) t_err(i);
    t_pair();
    t_soft(1'b1);
    t_soft(1'b0);
    close_out();
  end
endmodule
bind nsi_nmi_soft_irq nsi_chk i_nsi_chk (.CLOCK, .RESETN, .NMI_REQ, .SOFT_IRQ, .MSIE,
  .STORE_ERR, .LOAD_ERR, .FI_DBE_ERR, .FI_DCCM_ERR, .FI_NONDCCM_ERR, .NMI_VECTOR,
  .REDIRECT, .MSIP, .SOFT_IRQ_TAKE, .REDIRECT_PC, .MCAUSE);
